// ---- shared/flic_pkg.sv ----
package flic_pkg;

    localparam int FLIC_NSRC = 12;
    localparam int FLIC_IDXW = 4;
    localparam int FLIC_LVLW = 2;
    localparam int FLIC_VECW = 16;
    localparam int FLIC_NLVL = 4;

    // Bit of the global mask in the first enable register
    localparam int FLIC_GLOBAL_BIT = 7;

    // Reset values of the controller state
    localparam logic [3:0] FLIC_ISR_RST = 4'h0;
    localparam logic [15:0] FLIC_VEC_RST = 16'h0000;

    // Source index equals polling rank minus one (0 polls first)
    typedef enum logic [3:0] {
        FLIC_SRC_EXT0,
        FLIC_SRC_BROWNOUT,
        FLIC_SRC_WATCHDOG,
        FLIC_SRC_TIMER0,
        FLIC_SRC_TWOWIRE,
        FLIC_SRC_EXT1,
        FLIC_SRC_KEYBOARD,
        FLIC_SRC_COMP1,
        FLIC_SRC_TIMER1,
        FLIC_SRC_COMP2,
        FLIC_SRC_SERIAL,
        FLIC_SRC_TWOWIRE_TMO
    } flic_src_t;

    // Which enable/priority register pair holds the source: 0 first, 1 second
    localparam logic [11:0] FLIC_REG_SEL = 12'had0;

    // Bit position inside that register, by source index
    localparam logic [2:0] FLIC_BIT_POS [FLIC_NSRC] = '{
        3'h0, 3'h5, 3'h6, 3'h1, 3'h0, 3'h2,
        3'h1, 3'h5, 3'h3, 3'h2, 3'h4, 3'h7
    };

    localparam logic [15:0] FLIC_VECTOR [FLIC_NSRC] = '{
        16'h0003, 16'h002b, 16'h0053, 16'h000b, 16'h0033, 16'h0013,
        16'h003b, 16'h0063, 16'h001b, 16'h0043, 16'h0023, 16'h0073
    };

    // Sources able to end power-down
    localparam logic [11:0] FLIC_WAKE_MASK = 12'h2e7;

endpackage : flic_pkg

// ---- shared/flic_arb_if.sv ----
`timescale 1ns/1ps
interface flic_arb_if;
    import flic_pkg::*;

    logic [FLIC_NSRC-1:0] req;
    logic [FLIC_LVLW-1:0] lvl [FLIC_NSRC];
    logic valid;
    logic [FLIC_IDXW-1:0] idx;
    logic [FLIC_LVLW-1:0] win_lvl;

    modport arb (
        input req,
        input lvl,
        output valid,
        output idx,
        output win_lvl
    );

    modport top (
        output req,
        output lvl,
        input valid,
        input idx,
        input win_lvl
    );
endinterface : flic_arb_if

// ---- logic/flic_arbiter.sv ----
`timescale 1ns/1ps
module flic_arbiter import flic_pkg::*; (
    flic_arb_if.arb arb
);
    // Scan from the last rank (index 11) down to index 0 so the best rank at a level wins
    always_comb begin
        arb.valid = 1'b0;
        arb.idx = '0;
        arb.win_lvl = '0;
        for (int i = FLIC_NSRC - 1; i >= 0; i--) begin
            if (arb.req[i] && (!arb.valid || arb.lvl[i] >= arb.win_lvl)) begin // R8 R9 R10
                arb.valid = 1'b1;
                arb.idx = FLIC_IDXW'(i);
                arb.win_lvl = arb.lvl[i];
            end
        end
    end
endmodule : flic_arbiter

// ---- logic/flic_top.sv ----
`timescale 1ns/1ps
// What this block does
// R1 - Four priority levels; each source sits at exactly one level.
// R2 - Twelve request sources; the two-wire timeout has no visible flag.
// R3 - A source with its enable cleared never gets an interrupt taken.
// R4 - Cleared global mask in first enable register blocks every source.
// R5 - Level comes from high and low priority bits at the enable's position.
// R6 - Active routine is preempted only by a strictly higher level.
// R7 - A routine at the top level is never interrupted.
// R8 - Simultaneous requests of different levels: higher level served first.
// R9 - Simultaneous same-level requests resolved by fixed polling order.
// R10 - Polling order only breaks ties, never overrides the level.
// R11 - Polling ranks ext0, brownout, watchdog, timer0, ... timeout last.
// R12 - Each source branches to its own fixed vector address.
// R13 - Serial tx and rx done share one request, vector 0023h, bit 4.
// R14 - Enable bits placed at fixed positions of the two enable registers.
// R15 - Ext, brownout, keyboard, comparators, watchdog may wake power-down.
// R16 - Larger two-bit priority value is the higher level; zero at reset.
module flic_top import flic_pkg::*; (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Enable and priority registers
    input wire logic [7:0] i_irq_enable_first,
    input wire logic [7:0] i_irq_enable_second,
    input wire logic [7:0] i_prio_low_first,
    input wire logic [7:0] i_prio_high_first,
    input wire logic [7:0] i_prio_low_second,
    input wire logic [7:0] i_prio_high_second,
    // Peripheral request flags
    input wire logic i_ext0_request_flag,
    input wire logic i_ext1_request_flag,
    input wire logic i_timer0_overflow_flag,
    input wire logic i_timer1_overflow_flag,
    input wire logic i_serial_tx_done_flag,
    input wire logic i_serial_rx_done_flag,
    input wire logic i_brownout_flag,
    input wire logic i_twowire_attention_flag,
    input wire logic i_keyboard_flag,
    input wire logic i_comparator1_flag,
    input wire logic i_comparator2_flag,
    input wire logic i_watchdog_overflow_flag,
    input wire logic i_twowire_timeout_req,
    // Processor core handshake
    input wire logic i_irq_ack,
    input wire logic i_irq_return,
    output logic o_irq_req,
    output logic [FLIC_VECW-1:0] o_irq_vector,
    output logic [FLIC_IDXW-1:0] o_irq_source,
    output logic [FLIC_LVLW-1:0] o_irq_level,
    output logic [FLIC_NSRC-1:0] o_irq_taken,
    output logic [FLIC_NLVL-1:0] o_in_service,
    // Power-down wakeup
    output logic o_wakeup
);

    logic [FLIC_NSRC-1:0] raw_req;
    logic [FLIC_NSRC-1:0] en_vec;
    logic [FLIC_NSRC-1:0] eff_req;
    logic [FLIC_LVLW-1:0] src_lvl [FLIC_NSRC];
    logic [FLIC_NLVL-1:0] isr_q;
    logic [FLIC_LVLW-1:0] top_lvl;
    logic preempt_ok;
    logic take_now;
    logic req_d;
    logic [FLIC_LVLW-1:0] max_lvl;

    flic_arb_if arb ();

    // Raw requests in polling rank order
    always_comb begin
        raw_req = '0;
        raw_req[FLIC_SRC_EXT0] = i_ext0_request_flag; // R2 R11
        raw_req[FLIC_SRC_BROWNOUT] = i_brownout_flag;
        raw_req[FLIC_SRC_WATCHDOG] = i_watchdog_overflow_flag;
        raw_req[FLIC_SRC_TIMER0] = i_timer0_overflow_flag;
        raw_req[FLIC_SRC_TWOWIRE] = i_twowire_attention_flag;
        raw_req[FLIC_SRC_EXT1] = i_ext1_request_flag;
        raw_req[FLIC_SRC_KEYBOARD] = i_keyboard_flag;
        raw_req[FLIC_SRC_COMP1] = i_comparator1_flag;
        raw_req[FLIC_SRC_TIMER1] = i_timer1_overflow_flag;
        raw_req[FLIC_SRC_COMP2] = i_comparator2_flag;
        // Both serial flags fold into one request
        raw_req[FLIC_SRC_SERIAL] = i_serial_tx_done_flag
                                 | i_serial_rx_done_flag; // R13
        // Timeout request arrives as a bare level, no flag of its own
        raw_req[FLIC_SRC_TWOWIRE_TMO] = i_twowire_timeout_req; // R2
    end

    // Per-source enable and level, picked from the register pair
    always_comb begin
        for (int i = 0; i < FLIC_NSRC; i++) begin
            if (FLIC_REG_SEL[i]) begin
                en_vec[i] = i_irq_enable_second[FLIC_BIT_POS[i]]; // R14
                src_lvl[i] = {i_prio_high_second[FLIC_BIT_POS[i]],
                              i_prio_low_second[FLIC_BIT_POS[i]]}; // R5 R16
            end else begin
                en_vec[i] = i_irq_enable_first[FLIC_BIT_POS[i]]; // R14 R13
                src_lvl[i] = {i_prio_high_first[FLIC_BIT_POS[i]],
                              i_prio_low_first[FLIC_BIT_POS[i]]}; // R5 R16
            end
        end
    end

    // Global mask gates every source together
    assign eff_req = (raw_req & en_vec)
                   & {FLIC_NSRC{i_irq_enable_first[FLIC_GLOBAL_BIT]}}; // R3 R4

    assign arb.req = eff_req;
    assign arb.lvl = src_lvl; // R1

    flic_arbiter u_arbiter (
        .arb(arb)
    );

    // Highest level now in service
    always_comb begin
        top_lvl = '0;
        for (int l = 0; l < FLIC_NLVL; l++) begin
            if (isr_q[l]) begin
                top_lvl = FLIC_LVLW'(l);
            end
        end
    end

    // Only a strictly higher level may preempt; level 3 blocks everything
    assign preempt_ok = (isr_q == '0) || (arb.win_lvl > top_lvl); // R6 R7
    assign take_now = o_irq_req && i_irq_ack;
    // Request drops the cycle after acceptance so the core cannot take twice
    assign req_d = arb.valid && preempt_ok && !take_now; // R6 R8

    // In-service level stack; a new take wins over a same-cycle return
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            isr_q <= FLIC_ISR_RST;
        end else begin
            for (int l = 0; l < FLIC_NLVL; l++) begin
                if (take_now && o_irq_level == FLIC_LVLW'(l)) begin
                    isr_q[l] <= 1'b1; // R6
                end else if (i_irq_return && top_lvl == FLIC_LVLW'(l)) begin
                    isr_q[l] <= 1'b0;
                end
            end
        end
    end

    // Request, vector and source to the core
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_irq_req <= 1'b0;
            o_irq_vector <= FLIC_VEC_RST;
            o_irq_source <= '0;
            o_irq_level <= '0;
        end else begin
            o_irq_req <= req_d;
            if (!take_now) begin
                // Hold the accepted vector steady through the acknowledge
                o_irq_vector <= FLIC_VECTOR[arb.idx]; // R12 R13
                o_irq_source <= arb.idx;
                o_irq_level <= arb.win_lvl;
            end
        end
    end

    // One-cycle pulse telling the source its request was taken
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_irq_taken <= '0;
        end else begin
            o_irq_taken <= '0;
            if (take_now) begin
                o_irq_taken[o_irq_source] <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_in_service <= FLIC_ISR_RST;
        end else begin
            o_in_service <= isr_q;
        end
    end

    // Wakeup ignores the global mask: enable of the source is enough
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_wakeup <= 1'b0;
        end else begin
            o_wakeup <= |(raw_req & en_vec & FLIC_WAKE_MASK); // R15
        end
    end

    // Helper: highest pending level, for checking only
    always_comb begin
        max_lvl = '0;
        for (int i = 0; i < FLIC_NSRC; i++) begin
            if (eff_req[i] && src_lvl[i] > max_lvl) begin
                max_lvl = src_lvl[i];
            end
        end
    end

    a_global_mask: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R4
        !i_irq_enable_first[FLIC_GLOBAL_BIT] |=> !o_irq_req)
        else $error("request raised while global mask cleared");

    a_enable_gate: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R3
        o_irq_req |-> $past(en_vec[arb.idx]) && $past(raw_req[arb.idx]))
        else $error("request raised for a disabled source");

    a_top_level_hold: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R7
        isr_q[3] |=> !o_irq_req)
        else $error("top level routine was interrupted");

    a_strict_preempt: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R6
        o_irq_req && $past(isr_q != 4'h0) |-> o_irq_level > $past(top_lvl))
        else $error("preemption by equal or lower level");

    a_level_first: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R8
        arb.valid |-> arb.win_lvl == max_lvl && eff_req[arb.idx])
        else $error("winner is not at the highest pending level");

    a_rank_tie: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R9
        arb.valid && arb.idx != 4'h0 |->
        (eff_req & ((12'h001 << arb.idx) - 12'h001)) == 12'h000
        || src_lvl[0] != arb.win_lvl || !eff_req[0])
        else $error("rank 1 source lost a same-level tie");

    a_vector_map: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R12
        o_irq_req |-> o_irq_vector == FLIC_VECTOR[o_irq_source])
        else $error("vector does not match source");

    a_take_marks: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R6
        take_now |=> isr_q[$past(o_irq_level)] && !o_irq_req
        && o_irq_taken[$past(o_irq_source)])
        else $error("taken interrupt not marked in service");

    a_wake_source: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R15
        (i_timer0_overflow_flag && !(|(raw_req & en_vec & FLIC_WAKE_MASK)))
        |=> !o_wakeup)
        else $error("non-wake source caused wakeup");

    c_nested: cover property (@(posedge i_clk) disable iff (!i_reset_n)
        take_now && isr_q != 4'h0);
    c_tie: cover property (@(posedge i_clk) disable iff (!i_reset_n)
        arb.valid && $countones(eff_req) > 1);
    c_serial_take: cover property (@(posedge i_clk) disable iff (!i_reset_n)
        take_now && o_irq_source == FLIC_SRC_SERIAL);
    c_wake: cover property (@(posedge i_clk) disable iff (!i_reset_n)
        o_wakeup);

endmodule : flic_top

// ---- verif/flic_core_model.sv ----
`timescale 1ns/1ps
module flic_core_model (
    // Clock
    input wire logic i_clk,
    // Bench control
    input wire logic i_ack_en,
    input wire logic i_ret_cmd,
    // Controller side
    input wire logic i_irq_req,
    output logic o_irq_ack,
    output logic o_irq_return
);
    logic ret_seen_q = 1'b0;

    initial o_irq_ack = 1'b0;
    initial o_irq_return = 1'b0;

    // One-cycle accept pulse, never while the request is low
    always @(negedge i_clk) begin
        o_irq_ack <= i_ack_en && (i_irq_req === 1'b1) && !o_irq_ack;
    end

    // A toggle of the command becomes one return pulse
    always @(negedge i_clk) begin
        o_irq_return <= (i_ret_cmd != ret_seen_q);
        ret_seen_q <= i_ret_cmd;
    end
endmodule : flic_core_model

// ---- verif/four_level_interrupt_controller_bench.sv ----
`timescale 1ns/1ps
module four_level_interrupt_controller_bench import flic_pkg::*;;
    logic clk = 0;
    logic rst_n = 0;
    logic [7:0] en1 = '0, en2 = '0, pl1 = '0, ph1 = '0, pl2 = '0, ph2 = '0;
    logic [11:0] flg = '0;
    logic rx = 0;
    logic ack_en = 1, ret_cmd = 0;
    logic ack, ret, req, wake;
    logic [15:0] vec;
    logic [3:0] src, isv;
    logic [1:0] lvl;
    logic [11:0] tkn;
    int fails = 0, n_checks = 0, cyc = 0;
    // Own placement table; not taken from the package on purpose
    localparam logic [2:0] POS [12] = '{3'h0, 3'h5, 3'h6, 3'h1, 3'h0,
        3'h2, 3'h1, 3'h5, 3'h3, 3'h2, 3'h4, 3'h7};
    localparam logic [11:0] SEL = 12'had0;
    localparam logic [11:0] WAKE = 12'h2e7;
    localparam logic [15:0] VEC [12] = '{16'h0003, 16'h002b, 16'h0053,
        16'h000b, 16'h0033, 16'h0013, 16'h003b, 16'h0063, 16'h001b,
        16'h0043, 16'h0023, 16'h0073};

    always #4 clk = ~clk;

    flic_top i_dut (.i_clk(clk), .i_reset_n(rst_n),
        .i_irq_enable_first(en1), .i_irq_enable_second(en2),
        .i_prio_low_first(pl1), .i_prio_high_first(ph1),
        .i_prio_low_second(pl2), .i_prio_high_second(ph2),
        .i_ext0_request_flag(flg[0]), .i_brownout_flag(flg[1]),
        .i_watchdog_overflow_flag(flg[2]), .i_timer0_overflow_flag(flg[3]),
        .i_twowire_attention_flag(flg[4]), .i_ext1_request_flag(flg[5]),
        .i_keyboard_flag(flg[6]), .i_comparator1_flag(flg[7]),
        .i_timer1_overflow_flag(flg[8]), .i_comparator2_flag(flg[9]),
        .i_serial_tx_done_flag(flg[10]), .i_serial_rx_done_flag(rx),
        .i_twowire_timeout_req(flg[11]), .i_irq_ack(ack),
        .i_irq_return(ret), .o_irq_req(req), .o_irq_vector(vec),
        .o_irq_source(src), .o_irq_level(lvl), .o_irq_taken(tkn),
        .o_in_service(isv), .o_wakeup(wake));

    flic_core_model i_core (.i_clk(clk), .i_ack_en(ack_en),
        .i_ret_cmd(ret_cmd), .i_irq_req(req), .o_irq_ack(ack),
        .o_irq_return(ret));

    task wrap_up;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    // Whole run needs a few hundred cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            wrap_up();
        end
    end

    task chk(input logic [15:0] g, input logic [15:0] e, input string m);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("Error %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk

    task cfg(input int i, input logic e, input logic [1:0] l);
        if (SEL[i]) begin
            en2[POS[i]] = e;
            pl2[POS[i]] = l[0];
            ph2[POS[i]] = l[1];
        end else begin
            en1[POS[i]] = e;
            pl1[POS[i]] = l[0];
            ph1[POS[i]] = l[1];
        end
    endtask : cfg

    task do_reset;
        rst_n = 0;
        {en1, en2, pl1, ph1, pl2, ph2} = '0;
        flg = '0;
        rx = 0;
        repeat (3) @(negedge clk);
        // Vector tracks arbitration once running, so look during reset
        chk(req, 0, "reset req");
        chk(vec, 16'h0000, "reset vector");
        chk(isv, 0, "reset in service");
        rst_n = 1;
        @(negedge clk);
        chk(req, 0, "idle req");
        en1[7] = 1;
    endtask : do_reset

    task wait_req;
        for (int k = 0; k < 6; k++) begin
            @(negedge clk);
            if (req === 1'b1)
                break;
        end
        chk(req, 1, "request");
    endtask : wait_req

    task no_req;
        repeat (4) begin
            @(negedge clk);
            chk(req, 0, "blocked request");
        end
    endtask : no_req

    task service(input int i, input logic [1:0] l);
        wait_req();
        chk(vec, VEC[i], "vector");
        chk(src, i[3:0], "source");
        chk(lvl, l, "level");
        @(negedge clk);
        chk(tkn, 12'h1 << i, "taken");
        @(negedge clk);
        chk(isv[l], 1, "in service");
    endtask : service

    // Toggle lands off the model's sampling edge
    task ret_pop;
        @(posedge clk);
        ret_cmd <= ~ret_cmd;
        // Return early enough that a waiting request is not yet acked
        repeat (2) @(negedge clk);
    endtask : ret_pop

    task t_vectors;
        int s;
        do_reset();
        for (int i = 0; i < 13; i++) begin
            s = (i < 12) ? i : 10;
            cfg(s, 1, i[1:0]);
            if (i < 12)
                flg[s] = 1;
            else
                rx = 1;
            service(s, i[1:0]);
            flg[s] = 0;
            rx = 0;
            ret_pop();
            cfg(s, 0, 0);
        end
        $display("test vectors done");
    endtask : t_vectors

    task t_masks;
        do_reset();
        cfg(0, 1, 2'h1);
        en1[7] = 0;
        flg[0] = 1;
        no_req();
        en1[7] = 1;
        cfg(0, 0, 2'h1);
        no_req();
        ack_en = 0;
        cfg(0, 1, 2'h1);
        wait_req();
        repeat (3) @(negedge clk);
        chk(req, 1, "held request");
        chk(vec, VEC[0], "held vector");
        @(posedge clk) ack_en <= 1;
        service(0, 1);
        $display("test masks done");
    endtask : t_masks

    task t_poll;
        do_reset();
        for (int i = 0; i < 12; i++)
            cfg(i, 1, 2'h2);
        flg = 12'hfff;
        for (int i = 0; i < 12; i++) begin
            service(i, 2);
            flg[i] = 0;
            ret_pop();
        end
        do_reset();
        for (int i = 0; i < 12; i++)
            cfg(i, 1, 0);
        cfg(11, 1, 2'h3);
        cfg(8, 1, 2'h1);
        flg = 12'hfff;
        service(11, 3);
        no_req();
        $display("test poll done");
    endtask : t_poll

    task t_preempt;
        do_reset();
        cfg(5, 1, 2'h1);
        flg[5] = 1;
        service(5, 1);
        cfg(3, 1, 2'h1);
        cfg(1, 1, 2'h0);
        flg[3] = 1;
        flg[1] = 1;
        no_req();
        cfg(9, 1, 2'h2);
        flg[9] = 1;
        service(9, 2);
        cfg(6, 1, 2'h3);
        flg[6] = 1;
        service(6, 3);
        chk(isv, 4'he, "nested levels");
        flg[6] = 0;
        ret_pop();
        @(negedge clk);
        chk(isv, 4'h6, "after return");
        no_req();
        $display("test preempt done");
    endtask : t_preempt

    task t_wake;
        do_reset();
        en1[7] = 0;
        for (int i = 0; i < 12; i++) begin
            cfg(i, 1, 0);
            flg[i] = 1;
            repeat (2) @(negedge clk);
            chk(wake, WAKE[i], "wakeup");
            flg[i] = 0;
            cfg(i, 0, 0);
        end
        $display("test wake done");
    endtask : t_wake

    initial begin
        t_vectors();
        t_masks();
        t_poll();
        t_preempt();
        t_wake();
        wrap_up();
    end
endmodule : four_level_interrupt_controller_bench
